// ### logic/srf_pkg.sv
// Shared constants and types of the sector record formatter.
// Assumes one byte-rate clock shared by buffer, formatter and modulator.
package srf_pkg;

   // Layout of the recorded data field
   localparam int SYNC_BYTES = 4;
   localparam int ROW_COLUMNS = 38;
   localparam int ROWS_PER_RESYNC = 4;
   localparam int LOCK_BYTES = 50;
   localparam int LOCK_AFTER_BYTE = 304;
   localparam int TOTAL_BYTES = 9424;
   localparam int CNT_W = 14;
   // Drive information record: sequence bytes 8201 to 8204
   localparam int DIR_FIRST_BYTE = 8201;
   localparam int DIR_BYTES = 4;

   // Drive information record field positions
   localparam int B1_VERIFY_BIT = 6;
   localparam int B1_VPASS_BIT = 5;
   localparam int B1_CAUSE_MSB = 4;
   localparam int B2_ATTEMPT_LSB = 4;
   localparam int CAUSE_W = 5;
   localparam int ATTEMPT_W = 3;
   localparam int DRIVE_ID_W = 20;

   // Kind of each item handed to the modulator
   typedef enum logic [3:0] {
      SRF_K_SYNC = 4'h0,
      SRF_K_REF = 4'h1,
      SRF_K_DATA = 4'h2,
      SRF_K_RESYNC_ODD = 4'h3,
      SRF_K_RESYNC_EVEN = 4'h4,
      SRF_K_LOCK = 4'h5,
      SRF_K_XSYNC = 4'h6,
      SRF_K_XREF = 4'h7,
      SRF_K_POST = 4'h8
   } srf_kind_type;

   typedef enum logic [2:0] {
      SRF_SEC_USER = 3'h0,
      SRF_SEC_DISK_INFO = 3'h1,
      SRF_SEC_DEFECT_STRUCT = 3'h2,
      SRF_SEC_PRIMARY_DL = 3'h3,
      SRF_SEC_SECONDARY_DL = 3'h4
   } srf_sector_type;

   // One item of the recorded data field
   typedef struct packed {
      srf_kind_type kind;
      logic [7:0] data;
   } srf_item_type;

   // Per-sector drive status, sampled by the formatter at start
   typedef struct packed {
      logic verify_on;
      logic relocated;
      logic verify_fail;
      logic [CAUSE_W-1:0] cause;
      logic [3:0] attempt;
      logic [DRIVE_ID_W-1:0] drive_id;
   } srf_status_type;

endpackage : srf_pkg

// ### logic/srf_formatter.sv
// Sector record formatter: frames sequence bytes into the recorded data
// field and inserts the drive information record.
// Assumes the sector buffer presents bytes 1..9424 already interleaved,
// with CRC and ECC filled in; the modulator turns item kinds into patterns.
`timescale 1ns/1ps

// Summary of operation
// RQ1: Every sector write replaces the third control group with a 4-byte record.
// RQ2: Unassigned record bits are driven zero; readers ignore them.
// RQ3: Record byte 1 bit 6 shows whether write verification was on.
// RQ4: Verify-pass relocation flag is zero for sectors never relocated.
// RQ5: For relocated sectors that flag is one on verify error, zero on write error.
// RQ6: Low bits of byte 1 carry a free reason code readers ignore.
// RQ7: Relocation attempt field, byte 2 bits 6..4, is zero if never relocated.
// RQ8: Relocated sectors store the attempt number minus one there.
// RQ9: The 20-bit drive identifier fills byte 2 low nibble, bytes 3 and 4.
// RQ10: Drive identifier content is free; readers must not rely on it.
// RQ11: Disk-information and defect-management sectors zero the relocation fields.
// RQ12: Lock field bytes neither occupy nor advance an interleave row.
// RQ13: Resync after every 152 bytes, odd and even patterns alternate.
// RQ14: Reference field before byte 1 and after every 38 bytes.
// RQ15: A resync always precedes a reference at the same gap.
// RQ16: Lock, extra sync, extra reference follow the ninth reference field.
// RQ17: Status inputs are sampled once at the start of each sector write.
// RQ18: A sector type input selects forced-zero relocation fields.
module srf_formatter #(
   parameter int LOCK_LEN = srf_pkg::LOCK_BYTES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Sector control
   input wire logic start,
   input wire srf_pkg::srf_sector_type sector_kind,
   input wire srf_pkg::srf_status_type status,
   output logic busy_r,
   output logic done_r,
   // Sequence bytes from the sector buffer
   input wire logic in_valid,
   input wire logic [7:0] in_data,
   output logic in_ready_r,
   // Items to the modulator
   output logic out_valid_r,
   output srf_pkg::srf_item_type out_item_r,
   input wire logic out_ready
);
   import srf_pkg::*;

   localparam logic [CNT_W-1:0] TOTAL_C = CNT_W'(TOTAL_BYTES);
   localparam logic [CNT_W-1:0] LOCK_AT_C = CNT_W'(LOCK_AFTER_BYTE);
   localparam logic [CNT_W-1:0] DIR_LO_C = CNT_W'(DIR_FIRST_BYTE);
   localparam logic [CNT_W-1:0] DIR_HI_C =
      CNT_W'(DIR_FIRST_BYTE + DIR_BYTES - 1);
   localparam logic [5:0] COL_LAST_C = 6'(ROW_COLUMNS - 1);
   localparam logic [1:0] ROW_LAST_C = 2'(ROWS_PER_RESYNC - 1);
   localparam logic [5:0] SYNC_LAST_C = 6'(SYNC_BYTES - 1);
   localparam logic [5:0] LOCK_LAST_C = 6'(LOCK_LEN - 1);
   localparam logic [7:0] FILL_C = 8'h00;

   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_SYNC = 9'h002,
      ST_REF = 9'h004,
      ST_DATA = 9'h008,
      ST_RESYNC = 9'h010,
      ST_LOCK = 9'h020,
      ST_XSYNC = 9'h040,
      ST_XREF = 9'h080,
      ST_POST = 9'h100
   } srf_state_type;

   srf_state_type state_r;
   srf_status_type stat_r;
   srf_sector_type sect_r;
   logic [CNT_W-1:0] sent_r;
   logic [CNT_W-1:0] fetch_r;
   logic [5:0] col_r;
   logic [1:0] row_r;
   logic [5:0] sub_r;
   logic rs_odd_r;
   logic lock_done_r;
   logic [7:0] hold_r;
   logic hold_v_r;
   logic hold_v_nxt;
   logic buf_ready_r;
   srf_item_type spare_r;
   logic spare_v_r;
   logic wr_valid;
   srf_item_type wr_item;
   logic push;
   logic pop;
   logic consume;
   logic accept;
   logic [CNT_W-1:0] byte_no;
   logic [7:0] dir_byte [DIR_BYTES];

   // Zeroes the relocation fields of system sectors
   function automatic logic is_system(input srf_sector_type k);
      return k == SRF_SEC_DISK_INFO || k == SRF_SEC_DEFECT_STRUCT ||
             k == SRF_SEC_PRIMARY_DL || k == SRF_SEC_SECONDARY_DL; // RQ11
   endfunction : is_system

   // Drive information record, built from the sampled status
   always_comb begin
      logic reloc;
      reloc = stat_r.relocated && !is_system(sect_r); // RQ11
      dir_byte[0] = FILL_C; // RQ2
      dir_byte[1] = FILL_C; // RQ2
      dir_byte[0][B1_VERIFY_BIT] = stat_r.verify_on; // RQ3
      dir_byte[0][B1_VPASS_BIT] = reloc && stat_r.verify_fail; // RQ4 RQ5
      if (reloc) begin
         dir_byte[0][B1_CAUSE_MSB -: CAUSE_W] = stat_r.cause; // RQ6
         dir_byte[1][B2_ATTEMPT_LSB +: ATTEMPT_W] =
            ATTEMPT_W'(stat_r.attempt - 4'h1); // RQ8
      end
      // Never-relocated sectors keep the attempt field zero
      dir_byte[1][3:0] = stat_r.drive_id[19:16]; // RQ9 RQ7
      dir_byte[2] = stat_r.drive_id[15:8]; // RQ9 RQ10
      dir_byte[3] = stat_r.drive_id[7:0]; // RQ9
   end

   assign byte_no = sent_r + CNT_W'(1);
   assign consume = (state_r == ST_DATA) && hold_v_r && buf_ready_r;
   assign accept = in_valid && in_ready_r;
   assign hold_v_nxt = (hold_v_r && !consume) || accept;

   // Item offered to the buffer this cycle
   always_comb begin
      wr_valid = buf_ready_r;
      wr_item.kind = SRF_K_DATA;
      wr_item.data = FILL_C;
      case (state_r)
         ST_SYNC: wr_item.kind = SRF_K_SYNC;
         ST_REF: wr_item.kind = SRF_K_REF;
         ST_RESYNC: wr_item.kind =
            rs_odd_r ? SRF_K_RESYNC_ODD : SRF_K_RESYNC_EVEN; // RQ13
         ST_LOCK: wr_item.kind = SRF_K_LOCK;
         ST_XSYNC: wr_item.kind = SRF_K_XSYNC;
         ST_XREF: wr_item.kind = SRF_K_XREF;
         ST_POST: wr_item.kind = SRF_K_POST;
         ST_DATA: begin
            wr_valid = consume;
            if (byte_no >= DIR_LO_C && byte_no <= DIR_HI_C) begin
               wr_item.data = dir_byte[2'(byte_no - DIR_LO_C)]; // RQ1
            end else begin
               wr_item.data = hold_r;
            end
         end
         default: wr_valid = 1'b0;
      endcase
   end

   assign push = wr_valid;
   assign pop = out_valid_r && out_ready;

   // Sampling of sector status at the start
   always_ff @(posedge clock) begin
      if (!rstn) begin
         stat_r <= '0;
         sect_r <= SRF_SEC_USER;
      end else if (state_r == ST_IDLE && start) begin
         stat_r <= status; // RQ17
         sect_r <= sector_kind; // RQ18
      end
   end

   // Framing sequence
   always_ff @(posedge clock) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
         sent_r <= '0;
         col_r <= '0;
         row_r <= '0;
         sub_r <= '0;
         rs_odd_r <= 1'b1;
         lock_done_r <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: if (start) begin
               state_r <= ST_SYNC;
               sent_r <= '0;
               col_r <= '0;
               row_r <= '0;
               sub_r <= '0;
               rs_odd_r <= 1'b1;
               lock_done_r <= 1'b0;
            end
            ST_SYNC: if (push) begin
               sub_r <= sub_r + 6'h01;
               if (sub_r == SYNC_LAST_C) begin
                  sub_r <= '0;
                  state_r <= ST_REF; // RQ14
               end
            end
            ST_DATA: if (push) begin
               sent_r <= byte_no;
               col_r <= col_r + 6'h01;
               if (col_r == COL_LAST_C) begin
                  col_r <= '0;
                  row_r <= row_r + 2'h1;
                  // Resync first when both share a gap
                  state_r <= (row_r == ROW_LAST_C) ? ST_RESYNC : ST_REF; // RQ15
               end
            end
            ST_RESYNC: if (push) begin
               rs_odd_r <= !rs_odd_r; // RQ13
               state_r <= ST_REF; // RQ15
            end
            ST_REF: if (push) begin
               if (sent_r == TOTAL_C) begin
                  state_r <= ST_POST; // RQ14
               end else if (sent_r == LOCK_AT_C && !lock_done_r) begin
                  state_r <= ST_LOCK; // RQ16
               end else begin
                  state_r <= ST_DATA;
               end
            end
            // Column and row counters stay frozen through the lock field
            ST_LOCK: if (push) begin
               sub_r <= sub_r + 6'h01; // RQ12
               if (sub_r == LOCK_LAST_C) begin
                  sub_r <= '0;
                  state_r <= ST_XSYNC; // RQ16
               end
            end
            ST_XSYNC: if (push) begin
               sub_r <= sub_r + 6'h01;
               if (sub_r == SYNC_LAST_C) begin
                  sub_r <= '0;
                  state_r <= ST_XREF; // RQ16
               end
            end
            ST_XREF: if (push) begin
               lock_done_r <= 1'b1;
               state_r <= ST_DATA;
            end
            ST_POST: if (push) begin
               state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Status outputs
   always_ff @(posedge clock) begin
      if (!rstn) begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         busy_r <= (state_r != ST_IDLE && !(state_r == ST_POST && push)) ||
                   (state_r == ST_IDLE && start);
         done_r <= state_r == ST_POST && push;
      end
   end

   // Input holding register; half rate in exchange for a registered ready
   always_ff @(posedge clock) begin
      if (!rstn) begin
         hold_r <= '0;
         hold_v_r <= 1'b0;
         fetch_r <= '0;
         in_ready_r <= 1'b0;
      end else begin
         hold_v_r <= hold_v_nxt;
         if (accept) begin
            hold_r <= in_data;
         end
         if (state_r == ST_IDLE) begin
            fetch_r <= '0;
         end else if (accept) begin
            fetch_r <= fetch_r + CNT_W'(1);
         end
         in_ready_r <= state_r != ST_IDLE && state_r != ST_POST &&
                       !hold_v_nxt &&
                       (fetch_r + CNT_W'(accept)) != TOTAL_C;
      end
   end

   // Two-entry output buffer: head drives the port, spare absorbs a stall
   always_ff @(posedge clock) begin
      if (!rstn) begin
         out_valid_r <= 1'b0;
         out_item_r <= '0;
         spare_r <= '0;
         spare_v_r <= 1'b0;
         buf_ready_r <= 1'b0;
      end else begin
         if (pop && spare_v_r) begin
            out_item_r <= spare_r;
            spare_v_r <= 1'b0;
         end else if (pop || !out_valid_r) begin
            out_item_r <= wr_item;
            out_valid_r <= push;
         end else if (push) begin
            spare_r <= wr_item;
            spare_v_r <= 1'b1;
         end
         buf_ready_r <= !(spare_v_r && !pop) &&
                        !(push && out_valid_r && !pop);
      end
   end

endmodule : srf_formatter

// ### tb/srf_asserts.sv
// Checker on the formatter ports.
// Assumes it is bound onto every formatter instance.
`timescale 1ns/1ps
module srf_asserts
   import srf_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Control and streams
   input wire logic busy_r,
   input wire logic done_r,
   input wire logic in_valid,
   input wire logic in_ready_r,
   input wire logic out_valid_r,
   input wire srf_pkg::srf_item_type out_item_r,
   input wire logic out_ready
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   logic tk;
   srf_kind_type k;
   assign tk = out_valid_r && out_ready;
   assign k = out_item_r.kind;

   a_item_hold: assert property (out_valid_r && !out_ready |=> out_valid_r
      && $stable(out_item_r)) else $error("item moved while stalled");
   // Ready drops in the cycle after each byte is taken
   a_ready_half: assert property (in_ready_r && in_valid |=> !in_ready_r)
      else $error("input ready two cycles running");
   a_idle_quiet: assert property (!busy_r |-> !in_ready_r)
      else $error("byte taken while idle");
   a_done_pulse: assert property (done_r |=> !done_r)
      else $error("done longer than one cycle");
   a_sync_first: assert property ($rose(busy_r) |=> out_valid_r
      && k == SRF_K_SYNC) else $error("sector does not open with sync");
   a_fill_zero: assert property (out_valid_r && k != SRF_K_DATA
      |-> out_item_r.data == 8'h00) else $error("pattern item with data");
   a_resync_ref: assert property (tk && k inside {SRF_K_RESYNC_ODD,
      SRF_K_RESYNC_EVEN} |=> !out_valid_r || k == SRF_K_REF)
      else $error("resync not followed by reference");
   a_lock_order: assert property (tk && k == SRF_K_LOCK |=>
      !out_valid_r || k inside {SRF_K_LOCK, SRF_K_XSYNC})
      else $error("lock field broken");
   a_xsync_order: assert property (tk && k == SRF_K_XSYNC |=>
      !out_valid_r || k inside {SRF_K_XSYNC, SRF_K_XREF})
      else $error("extra sync not followed by extra reference");
   a_ref_next: assert property (tk && k == SRF_K_REF |=>
      !out_valid_r || k inside {SRF_K_DATA, SRF_K_LOCK, SRF_K_POST})
      else $error("reference followed by pattern");

   c_done: cover property (done_r);
   c_stall: cover property (out_valid_r && !out_ready);
   c_lock: cover property (tk && k == SRF_K_LOCK);
endmodule : srf_asserts

bind srf_formatter srf_asserts srf_asserts_inst (.clock(clock),
   .rstn(rstn), .busy_r(busy_r), .done_r(done_r), .in_valid(in_valid),
   .in_ready_r(in_ready_r),
   .out_valid_r(out_valid_r), .out_item_r(out_item_r),
   .out_ready(out_ready));

// ### tb/srf_modulator_model.sv
// Modulator stand-in: takes items, counts kinds, keeps the record bytes.
// Assumes the bench reads its results once the sector has drained.
`timescale 1ns/1ps
module srf_modulator_model
   import srf_pkg::*;
(
   // Clock, reset and bench control
   input wire logic clock,
   input wire logic rstn,
   input wire logic start,
   input wire logic stall,
   // Item stream
   input wire logic out_valid_r,
   input wire srf_pkg::srf_item_type out_item_r,
   output logic out_ready,
   // Results
   output logic [15:0] kcnt [0:8],
   output logic [7:0] rec [0:3],
   output logic [15:0] bad
);
   logic [15:0] dn;
   logic [15:0] nx;
   logic in_rec;
   logic bad_data;
   logic bad_place;
   srf_kind_type prev;
   assign nx = dn + 16'h0001;
   assign in_rec = nx >= 16'(DIR_FIRST_BYTE)
      && nx < 16'(DIR_FIRST_BYTE + DIR_BYTES);
   assign bad_data = !in_rec && out_item_r.data != nx[7:0];
   // A row opens right after a reference; lock bytes must not shift it
   assign bad_place = nx % 16'h0026 == 16'h0001
      && !(prev inside {SRF_K_REF, SRF_K_XREF});

   // Every other cycle when asked, so the two-entry buffer fills up
   always_ff @(posedge clock) begin
      out_ready <= rstn && (!stall || !out_ready);
   end

   always_ff @(posedge clock) begin
      if (!rstn || start) begin
         kcnt <= '{default: 16'h0000};
         rec <= '{default: 8'hEE};
         dn <= 16'h0000;
         bad <= 16'h0000;
         prev <= SRF_K_SYNC;
      end else if (out_valid_r && out_ready) begin
         kcnt[out_item_r.kind] <= kcnt[out_item_r.kind] + 16'h0001;
         prev <= out_item_r.kind;
         if (out_item_r.kind == SRF_K_DATA) begin
            dn <= nx;
            bad <= bad + 16'(bad_data) + 16'(bad_place);
            if (in_rec) begin
               rec[2'(nx - 16'(DIR_FIRST_BYTE))] <= out_item_r.data;
            end
         end
      end
   end
endmodule : srf_modulator_model

// ### tb/srf_formatter_tb.sv
// Bench: six sectors through the formatter into the modulator model.
// Assumes the sector buffer always has its next byte ready.
`timescale 1ns/1ps
module srf_formatter_tb;
   import srf_pkg::*;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic start = 1'b0;
   logic in_valid = 1'b0;
   logic stall = 1'b0;
   logic [7:0] in_data = 8'h01;
   srf_sector_type sector_kind = SRF_SEC_USER;
   srf_status_type status = '0;
   logic busy_r, done_r, in_ready_r, out_valid_r, out_ready;
   srf_item_type out_item_r;
   logic [15:0] kcnt [0:8];
   logic [7:0] rec [0:3];
   logic [15:0] bad;
   // Per sector: sync, ref, data, odd, even, lock, xsync, xref, post
   logic [15:0] kexp [0:8] = '{16'h0004, 16'h00F9, 16'h24D0, 16'h001F,
      16'h001F, 16'h0002, 16'h0004, 16'h0001, 16'h0001};
   int n_fail = 0;
   int n_checks = 0;
   int cyc = 0;
   int n_done = 0;

   always #25 clock = ~clock;

   srf_formatter #(.LOCK_LEN(2)) srf_formatter_inst (.clock(clock),
      .rstn(rstn), .start(start), .sector_kind(sector_kind),
      .status(status), .busy_r(busy_r), .done_r(done_r),
      .in_valid(in_valid), .in_data(in_data), .in_ready_r(in_ready_r),
      .out_valid_r(out_valid_r), .out_item_r(out_item_r),
      .out_ready(out_ready));

   srf_modulator_model srf_modulator_model_inst (.clock(clock),
      .rstn(rstn), .start(start), .stall(stall),
      .out_valid_r(out_valid_r), .out_item_r(out_item_r),
      .out_ready(out_ready), .kcnt(kcnt), .rec(rec), .bad(bad));

   // Byte n carries n, so misplaced bytes show in the model
   always @(posedge clock) begin
      if (in_valid && in_ready_r) begin
         in_data <= in_data + 8'h01;
      end
      if (done_r) begin
         n_done <= n_done + 1;
      end
   end

   task check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task test_done;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done

   always @(posedge clock) begin
      cyc = cyc + 1;
      if (cyc == 150000) begin
         n_fail = n_fail + 1;
         test_done();
      end
   end

   // Status is scrambled after start; the record must keep the old one
   task run(input srf_sector_type k, input srf_status_type s,
      input logic [31:0] exp, input logic st);
      int i;
      int d0;
      @(posedge clock);
      d0 = n_done;
      sector_kind <= k;
      status <= s;
      in_data <= 8'h01;
      stall <= st;
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      status <= ~s;
      sector_kind <= SRF_SEC_USER;
      i = 0;
      do begin
         @(posedge clock);
         #1;
         i = i + 1;
      end while ((busy_r || out_valid_r) && i < 40000);
      // A sector that never drains counts as a mismatch here
      check(16'(busy_r || out_valid_r), 16'h0000);
      check(16'(n_done - d0), 16'h0001);
      check({rec[0], rec[1]}, exp[31:16]);
      check({rec[2], rec[3]}, exp[15:0]);
      for (i = 0; i < 9; i++) begin
         check(kcnt[i], kexp[i]);
      end
      check(bad, 16'h0000);
      $display("sector of kind %0d finished", k);
   endtask : run

   initial begin
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      in_valid <= 1'b1;
      // Verify failure without relocation must not set the pass flag
      run(SRF_SEC_USER, {3'b101, 5'h1F, 4'h5, 20'hABCDE},
         32'h400ABCDE, 1'b0);
      run(SRF_SEC_USER, {3'b011, 5'h15, 4'h8, 20'h12345},
         32'h35712345, 1'b1);
      for (int k = 1; k < 5; k++) begin
         run(srf_sector_type'(k), {3'b111, 5'h15, 4'h8, 20'h12345},
            32'h40012345, 1'b0);
      end
      test_done();
   end
endmodule : srf_formatter_tb
